// >>> core/stxec_defines.svh
// Register map, field positions and reset values of the serial event/control block
`ifndef STXEC_DEFINES_SVH
`define STXEC_DEFINES_SVH

// Register byte offsets
`define STXEC_OFS_INDEX 16'h1080
`define STXEC_OFS_MASK 16'h1088
`define STXEC_OFS_RAW 16'h1090
`define STXEC_OFS_MASKED 16'h1098
`define STXEC_OFS_SET 16'h10A0
`define STXEC_OFS_CLEAR 16'h10A8
`define STXEC_OFS_MODE 16'h10E0
`define STXEC_OFS_REEVAL 16'h10E4
`define STXEC_OFS_SERIAL_CONTROL_ZERO 16'h1100
`define STXEC_OFS_COUNT 16'h1110

// Field positions
`define STXEC_BIT_TX 4
`define STXEC_BIT_REEVAL 0
`define STXEC_BIT_SELECT_INACTIVE_COUNTER_CLEAR 14
`define STXEC_MSB_CHIP_SELECT_LINE_CHOICE 13
`define STXEC_LSB_CHIP_SELECT_LINE_CHOICE 12
`define STXEC_BIT_PHASE 9
`define STXEC_BIT_POL 8
`define STXEC_BIT_PACK 7
`define STXEC_MSB_FF 6
`define STXEC_LSB_FF 5

// Fixed values
`define STXEC_MODE_VALUE 32'h00000029
`define STXEC_MODE_OFF 2'h0
`define STXEC_MODE_SW 2'h1
`define STXEC_MODE_HW 2'h2
`define STXEC_IDX_NONE 8'h00
`define STXEC_IDX_TX 8'h05
`define STXEC_FF_SYNC 2'h2
`define STXEC_ZERO32 32'h00000000
`define STXEC_CS_IDLE 4'hF

`endif

// >>> core/stxec_pkg.sv
// Types shared by the serial event/control block
package stxec_pkg;

    typedef struct packed {
        logic select_inactive_counter_clear;
        logic [1:0] chip_select_line_choice;
        logic phase;
        logic pol;
        logic pack;
        logic [1:0] ff;
    } stxec_ctl_t;

    typedef struct packed {
        logic sclk_idle;
        logic capture_rise;
        logic pack_en;
        logic [3:0] cs_out_n;
        logic irq;
    } stxec_cfg_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        stxec_ctl_t ctl;
        logic mask;
        logic raw;
        logic reeval;
        logic [4:0] g1;
        logic [4:0] g2;
        stxec_cfg_t cfg;
    } stxec_st_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic [4:0] gray;
    } stxec_lnk_t;

endpackage

// >>> core/stxec_top.sv
// Transmit event flags, event line modes, re-evaluation strobe and control register 0
//
// Overview of operation
// - A 1 written to the transmit bit of the set register sets the raw transmit flag.
// - A software-set flag shows in the masked status only while its mask bit is on.
// - A 0 written to the transmit bit of the set register changes nothing.
// - A 1 written to the transmit bit of the clear register clears the raw flag.
// - Line mode fields encode 0 disabled, 1 software-cleared, 2 hardware-cleared.
// - Line modes read fixed: line 2 and line 1 hardware, line 0 software.
// - A 1 written to bit 0 of the re-evaluate register re-drives the interrupt output.
// - In peripheral operation with auto-clear set, chip select going inactive clears the bit counter.
// - A two-bit field picks which of four chip-select lines is driven or watched.
// - Phase 0 captures on the first clock edge, phase 1 on the second.
// - In polarity/phase format the idle serial clock is low for polarity 0, high for 1.
// - The packing enable bit turns frame packing on and off.
// - Masked status is the AND of mask bit and raw flag.
// - The transmit event is unmasked by bit 4 of the mask register.
// - Phase and polarity apply only in the three- and four-wire polarity/phase formats.
`timescale 1ns/1ps
`include "stxec_defines.svh"

module stxec_top
    import stxec_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Datapath side, same clock
    input wire logic tx_evt,
    input wire logic tx_hw_clr,
    input wire logic ctrl_sel,
    input wire logic xfer_active,
    output stxec_cfg_t cfg_o,
    // Link side
    input wire logic link_clk,
    input wire logic [3:0] cs_in_n
);

    stxec_st_t st_r;
    stxec_st_t st_nxt;
    stxec_lnk_t lnk_r;
    stxec_lnk_t lnk_nxt;
    logic link_clr;
    logic cs_sel_n;
    logic [4:0] cnt_bin;

    logic acc_setup;
    logic acc_done;
    logic wr_done;
    logic rd_done;
    logic masked;

    assign acc_setup = psel & penable & ~st_r.pready;
    assign acc_done = psel & penable & st_r.pready;
    assign wr_done = acc_done & pwrite;
    assign rd_done = acc_done & ~pwrite;
    assign masked = st_r.raw & st_r.mask;

    // Register the whole state; one bus wait state keeps every bus output on a flop
    always_comb begin
        logic set_req;
        logic clr_req;
        logic hit;
        logic [31:0] rd;
        set_req = 1'b0;
        clr_req = 1'b0;
        hit = 1'b1;
        rd = `STXEC_ZERO32;
        st_nxt = st_r;

        // Decode for the read answer, taken during the first access cycle
        case (paddr)
            `STXEC_OFS_INDEX: begin
                rd[7:0] = masked ? `STXEC_IDX_TX : `STXEC_IDX_NONE;
            end
            `STXEC_OFS_MASK: begin
                rd[`STXEC_BIT_TX] = st_r.mask;
            end
            `STXEC_OFS_RAW: begin
                rd[`STXEC_BIT_TX] = st_r.raw;
            end
            `STXEC_OFS_MASKED: begin
                rd[`STXEC_BIT_TX] = masked;
            end
            `STXEC_OFS_MODE: begin
                rd = `STXEC_MODE_VALUE;
            end
            `STXEC_OFS_SERIAL_CONTROL_ZERO: begin
                rd[`STXEC_BIT_SELECT_INACTIVE_COUNTER_CLEAR] = st_r.ctl.select_inactive_counter_clear;
                rd[`STXEC_MSB_CHIP_SELECT_LINE_CHOICE:`STXEC_LSB_CHIP_SELECT_LINE_CHOICE] = st_r.ctl.chip_select_line_choice;
                rd[`STXEC_BIT_PHASE] = st_r.ctl.phase;
                rd[`STXEC_BIT_POL] = st_r.ctl.pol;
                rd[`STXEC_BIT_PACK] = st_r.ctl.pack;
                rd[`STXEC_MSB_FF:`STXEC_LSB_FF] = st_r.ctl.ff;
            end
            `STXEC_OFS_COUNT: begin
                rd[4:0] = cnt_bin;
            end
            `STXEC_OFS_SET, `STXEC_OFS_CLEAR, `STXEC_OFS_REEVAL: begin
                rd = `STXEC_ZERO32;
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        st_nxt.pready = acc_setup;
        st_nxt.pslverr = acc_setup & ~hit;
        if (acc_setup) begin
            st_nxt.prdata = pwrite ? `STXEC_ZERO32 : rd;
        end

        st_nxt.reeval = 1'b0;
        if (wr_done) begin
            case (paddr)
                `STXEC_OFS_SET: begin
                    set_req = pwdata[`STXEC_BIT_TX];
                end
                `STXEC_OFS_CLEAR: begin
                    clr_req = pwdata[`STXEC_BIT_TX];
                end
                `STXEC_OFS_MASK: begin
                    st_nxt.mask = pwdata[`STXEC_BIT_TX];
                end
                `STXEC_OFS_REEVAL: begin
                    st_nxt.reeval = pwdata[`STXEC_BIT_REEVAL];
                end
                `STXEC_OFS_SERIAL_CONTROL_ZERO: begin
                    // Only documented fields store, the rest is dropped
                    st_nxt.ctl.select_inactive_counter_clear = pwdata[`STXEC_BIT_SELECT_INACTIVE_COUNTER_CLEAR];
                    st_nxt.ctl.chip_select_line_choice = pwdata[`STXEC_MSB_CHIP_SELECT_LINE_CHOICE:`STXEC_LSB_CHIP_SELECT_LINE_CHOICE];
                    st_nxt.ctl.phase = pwdata[`STXEC_BIT_PHASE];
                    st_nxt.ctl.pol = pwdata[`STXEC_BIT_POL];
                    st_nxt.ctl.pack = pwdata[`STXEC_BIT_PACK];
                    st_nxt.ctl.ff = pwdata[`STXEC_MSB_FF:`STXEC_LSB_FF];
                end
                default: begin
                end
            endcase
        end

        // A read of the index hands over the pending event and retires it
        if (rd_done && paddr == `STXEC_OFS_INDEX && masked) begin
            clr_req = 1'b1;
        end

        // Set beats every clear source in the same cycle
        if (set_req || tx_evt) begin
            st_nxt.raw = 1'b1;
        end else if (clr_req || tx_hw_clr) begin
            st_nxt.raw = 1'b0;
        end

        // Strobe drops the line for one cycle so an edge-sensitive sink sees it again
        st_nxt.cfg.irq = masked & ~st_r.reeval;

        // Phase/polarity only take effect in the polarity/phase formats
        if (st_r.ctl.ff < `STXEC_FF_SYNC) begin
            st_nxt.cfg.sclk_idle = st_r.ctl.pol;
            st_nxt.cfg.capture_rise = st_r.ctl.pol ~^ st_r.ctl.phase;
        end else begin
            st_nxt.cfg.sclk_idle = 1'b0;
            st_nxt.cfg.capture_rise = 1'b1;
        end
        st_nxt.cfg.pack_en = st_r.ctl.pack;

        st_nxt.cfg.cs_out_n = `STXEC_CS_IDLE;
        if (ctrl_sel && xfer_active) begin
            st_nxt.cfg.cs_out_n[st_r.ctl.chip_select_line_choice] = 1'b0;
        end

        // Bit counter gray code crossing from the link clock
        st_nxt.g1 = lnk_r.gray;
        st_nxt.g2 = st_r.g1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
            // Chip selects sit inactive through reset rather than all asserted
            st_r.cfg.cs_out_n <= `STXEC_CS_IDLE;
            st_r.cfg.capture_rise <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        cnt_bin[4] = st_r.g2[4];
        for (int i = 3; i >= 0; i--) begin
            cnt_bin[i] = cnt_bin[i + 1] ^ st_r.g2[i];
        end
    end

    // Link domain: the link clock stops between frames, so the counter clear
    // is taken straight from the chip-select level rather than waiting for an edge.
    // Select and auto-clear are quasi-static; change them only while idle.
    assign cs_sel_n = cs_in_n[st_r.ctl.chip_select_line_choice];
    assign link_clr = rst | (st_r.ctl.select_inactive_counter_clear & ~ctrl_sel & cs_sel_n);

    always_comb begin
        lnk_nxt = lnk_r;
        if (!cs_sel_n) begin
            lnk_nxt.cnt = lnk_r.cnt + 5'h01;
        end
        lnk_nxt.gray = lnk_nxt.cnt ^ (lnk_nxt.cnt >> 1);
    end

    always_ff @(posedge link_clk or posedge link_clr) begin
        if (link_clr) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign cfg_o = st_r.cfg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence seq_write(logic [15:0] ofs, logic bitval);
        wr_done && paddr == ofs && pwdata[`STXEC_BIT_TX] == bitval;
    endsequence

    sequence seq_quiet;
        !tx_evt && !tx_hw_clr;
    endsequence

    sequence seq_read(logic [15:0] ofs);
        acc_setup && !pwrite && paddr == ofs;
    endsequence

    chk_set_raw: assert property (
        seq_write(`STXEC_OFS_SET, 1'b1) |=> st_r.raw)
        else $error("set write did not raise raw flag");

    chk_set_zero: assert property (
        (seq_write(`STXEC_OFS_SET, 1'b0) and seq_quiet) |=> st_r.raw == $past(st_r.raw))
        else $error("zero set write changed raw flag");

    chk_clear_raw: assert property (
        (seq_write(`STXEC_OFS_CLEAR, 1'b1) and seq_quiet) |=> !st_r.raw ##1 !cfg_o.irq)
        else $error("clear write left flag or interrupt up");

    chk_set_wins: assert property (
        (tx_evt && wr_done && paddr == `STXEC_OFS_CLEAR) |=> st_r.raw)
        else $error("clear beat a simultaneous set");

    chk_masked_irq: assert property (
        (seq_write(`STXEC_OFS_SET, 1'b1) and seq_quiet) ##1 (!st_r.reeval && !rd_done)
        |=> cfg_o.irq == st_r.mask)
        else $error("interrupt does not follow mask after software set");

    chk_mode_read: assert property (
        (acc_setup && !pwrite && paddr == `STXEC_OFS_MODE)
        |=> pready && prdata == `STXEC_MODE_VALUE)
        else $error("line mode read wrong");

    chk_reeval_drop: assert property (
        (wr_done && paddr == `STXEC_OFS_REEVAL && pwdata[`STXEC_BIT_REEVAL])
        |=> st_r.reeval ##1 !cfg_o.irq)
        else $error("re-evaluate strobe did not re-drive interrupt");

    chk_cs_select: assert property (
        (ctrl_sel && xfer_active) |=> cfg_o.cs_out_n == ~(4'h1 << $past(st_r.ctl.chip_select_line_choice)))
        else $error("wrong chip-select line driven");

    chk_idle_pol: assert property (
        (st_r.ctl.ff < `STXEC_FF_SYNC) |=> cfg_o.sclk_idle == $past(st_r.ctl.pol))
        else $error("idle clock level does not follow polarity");

    chk_pack_en: assert property (
        $changed(st_r.ctl.pack) |=> cfg_o.pack_en == $past(st_r.ctl.pack))
        else $error("packing enable not passed on");

    chk_bus_answer: assert property (
        acc_setup |=> pready ##1 !pready)
        else $error("bus answer timing broken");

    chk_cs_reset: assert property (
        disable iff (1'b0) rst |=> cfg_o.cs_out_n == `STXEC_CS_IDLE)
        else $error("chip selects not idle after reset");

    chk_cs_idle: assert property (
        !(ctrl_sel && xfer_active) |=> cfg_o.cs_out_n == `STXEC_CS_IDLE)
        else $error("chip select driven outside a transfer");

    chk_masked_read: assert property (
        seq_read(`STXEC_OFS_MASKED)
        |=> prdata[`STXEC_BIT_TX] == ($past(st_r.raw) && $past(st_r.mask)))
        else $error("masked status is not mask and raw");

    chk_raw_read: assert property (
        seq_read(`STXEC_OFS_RAW) |=> prdata == ({31'h0, $past(st_r.raw)} << `STXEC_BIT_TX))
        else $error("raw status read wrong");

    chk_mode_fields: assert property (
        seq_read(`STXEC_OFS_MODE) |=> prdata[5:4] == `STXEC_MODE_HW
            && prdata[3:2] == `STXEC_MODE_HW && prdata[1:0] == `STXEC_MODE_SW)
        else $error("line mode fields wrong");

    chk_index_read: assert property (
        seq_read(`STXEC_OFS_INDEX)
        |=> prdata[7:0] == ($past(masked) ? `STXEC_IDX_TX : `STXEC_IDX_NONE))
        else $error("pending index read wrong");

    chk_index_retire: assert property (
        (rd_done && paddr == `STXEC_OFS_INDEX && masked && !tx_evt) |=> !st_r.raw)
        else $error("index read did not retire the event");

    chk_mask_write: assert property (
        (wr_done && paddr == `STXEC_OFS_MASK) |=> st_r.mask == $past(pwdata[`STXEC_BIT_TX]))
        else $error("mask write not stored");

    chk_clear_zero: assert property (
        (seq_write(`STXEC_OFS_CLEAR, 1'b0) and seq_quiet) |=> st_r.raw == $past(st_r.raw))
        else $error("zero clear write changed raw flag");

    chk_hw_clear: assert property (
        (tx_hw_clr && !tx_evt && !(wr_done && paddr == `STXEC_OFS_SET)) |=> !st_r.raw)
        else $error("hardware clear left raw flag up");

    chk_evt_set: assert property (
        tx_evt |=> st_r.raw)
        else $error("hardware event did not raise raw flag");

    chk_ctl_store: assert property (
        (wr_done && paddr == `STXEC_OFS_SERIAL_CONTROL_ZERO)
        |=> st_r.ctl.chip_select_line_choice == $past(pwdata[`STXEC_MSB_CHIP_SELECT_LINE_CHOICE:`STXEC_LSB_CHIP_SELECT_LINE_CHOICE]))
        else $error("line choice not stored");

    chk_select_inactive_counter_clear_store: assert property (
        (wr_done && paddr == `STXEC_OFS_SERIAL_CONTROL_ZERO)
        |=> st_r.ctl.select_inactive_counter_clear == $past(pwdata[`STXEC_BIT_SELECT_INACTIVE_COUNTER_CLEAR]))
        else $error("auto-clear bit not stored");

    chk_pack_store: assert property (
        (wr_done && paddr == `STXEC_OFS_SERIAL_CONTROL_ZERO)
        |=> st_r.ctl.pack == $past(pwdata[`STXEC_BIT_PACK]))
        else $error("packing bit not stored");

    chk_phase_edge: assert property (
        (st_r.ctl.ff < `STXEC_FF_SYNC)
        |=> cfg_o.capture_rise == ($past(st_r.ctl.pol) == $past(st_r.ctl.phase)))
        else $error("capture edge does not follow phase");

    chk_fmt_gate: assert property (
        (st_r.ctl.ff >= `STXEC_FF_SYNC) |=> !cfg_o.sclk_idle && cfg_o.capture_rise)
        else $error("phase or polarity leaked into other formats");

    chk_write_zero: assert property (
        (acc_setup && pwrite) |=> prdata == `STXEC_ZERO32)
        else $error("write answer not zero");

    chk_reeval_idle: assert property (
        !(wr_done && paddr == `STXEC_OFS_REEVAL) |=> !st_r.reeval)
        else $error("re-evaluate strobe without a write");

    // Level check: the auto-clear is asynchronous, so no link edge is needed
    chk_link_clear: assert property (
        (st_r.ctl.select_inactive_counter_clear && !ctrl_sel && cs_in_n[st_r.ctl.chip_select_line_choice]) |-> lnk_r.cnt == 5'h00)
        else $error("bit counter not held clear with select inactive");

endmodule

// >>> tb/stxec_partner.sv
// Far-side serial peer: chip selects and a link clock gated to frames
`timescale 1ns/1ps
module stxec_partner (
    // Link pins
    output logic link_clk,
    output logic [3:0] cs_in_n
);
    initial begin
        link_clk = 1'b0;
        cs_in_n = 4'hF;
    end
    // Selects one line, the rest stay inactive
    task automatic open_frame(input int sel);
        #11 cs_in_n[sel] = 1'b0;
    endtask
    // Clock stands low outside frames; rising edge is the capture edge
    task automatic clocks(input int n);
        repeat (n) begin
            #16 link_clk = 1'b1;
            #16 link_clk = 1'b0;
        end
    endtask
    task automatic close_frame();
        #11 cs_in_n = 4'hF;
    endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the serial event/control block
`timescale 1ns/1ps
`include "stxec_defines.svh"
module tb_top;
    import stxec_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_evt = 1'b0;
    logic tx_hw_clr = 1'b0;
    logic ctrl_sel = 1'b0;
    logic xfer_active = 1'b0;
    stxec_cfg_t cfg_o;
    logic link_clk;
    logic [3:0] cs_in_n;
    logic [31:0] rd;
    logic er;
    int miscompares = 0;
    int n_tests = 0;

    always #25 mclk = ~mclk;

    stxec_top i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_evt(tx_evt), .tx_hw_clr(tx_hw_clr), .ctrl_sel(ctrl_sel),
        .xfer_active(xfer_active), .cfg_o(cfg_o), .link_clk(link_clk), .cs_in_n(cs_in_n));
    stxec_partner i_peer (.link_clk(link_clk), .cs_in_n(cs_in_n));

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Waits on pready without assuming the wait-state count
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1, "pready timeout");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rchk(input logic [15:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, e, m);
    endtask

    task automatic t_reset();
        rchk(`STXEC_OFS_MODE, 32'h00000029, "mode");
        rchk(`STXEC_OFS_SERIAL_CONTROL_ZERO, 32'h00000000, "serial_control_zero reset");
        rchk(`STXEC_OFS_RAW, 32'h00000000, "raw reset");
        $display("t_reset done");
    endtask

    task automatic t_events();
        apb(1'b1, `STXEC_OFS_SET, 32'hFFFFFFEF);
        rchk(`STXEC_OFS_RAW, 32'h00000000, "set zero");
        apb(1'b1, `STXEC_OFS_SET, 32'h00000010);
        rchk(`STXEC_OFS_RAW, 32'h00000010, "set tx");
        rchk(`STXEC_OFS_MASKED, 32'h00000000, "masked off");
        apb(1'b1, `STXEC_OFS_MASK, 32'h00000010);
        rchk(`STXEC_OFS_MASKED, 32'h00000010, "masked on");
        chk({31'h0, cfg_o.irq}, 32'h1, "irq");
        apb(1'b1, `STXEC_OFS_CLEAR, 32'h00000000);
        rchk(`STXEC_OFS_RAW, 32'h00000010, "clear zero");
        apb(1'b1, `STXEC_OFS_CLEAR, 32'h00000010);
        rchk(`STXEC_OFS_RAW, 32'h00000000, "clear tx");
        apb(1'b1, `STXEC_OFS_SET, 32'h00000010);
        rchk(`STXEC_OFS_MASK, 32'h00000010, "mask read");
        rchk(`STXEC_OFS_INDEX, {24'h0, `STXEC_IDX_TX}, "index tx");
        rchk(`STXEC_OFS_INDEX, 32'h00000000, "index retired");
        rchk(`STXEC_OFS_RAW, 32'h00000000, "raw retired");
        $display("t_events done");
    endtask

    task automatic t_reeval();
        logic low;
        low = 1'b0;
        apb(1'b1, `STXEC_OFS_SET, 32'h00000010);
        apb(1'b1, `STXEC_OFS_REEVAL, 32'h00000001);
        repeat (4) begin
            if (cfg_o.irq === 1'b0) low = 1'b1;
            @(posedge mclk);
        end
        chk({31'h0, low}, 32'h1, "reeval drop");
        chk({31'h0, cfg_o.irq}, 32'h1, "reeval back");
        tx_hw_clr <= 1'b1;
        @(posedge mclk);
        tx_hw_clr <= 1'b0;
        rchk(`STXEC_OFS_RAW, 32'h00000000, "hw clear");
        // Event pulse lands exactly on the edge that completes the clear
        fork
            apb(1'b1, `STXEC_OFS_CLEAR, 32'h00000010);
            begin
                do @(posedge mclk); while (!(psel && penable && !pready));
                tx_evt <= 1'b1;
                @(posedge mclk);
                tx_evt <= 1'b0;
            end
        join
        rchk(`STXEC_OFS_RAW, 32'h00000010, "set wins");
        apb(1'b1, `STXEC_OFS_CLEAR, 32'h00000010);
        $display("t_reeval done");
    endtask

    task automatic t_ctl();
        apb(1'b1, `STXEC_OFS_SERIAL_CONTROL_ZERO, 32'hFFFFFFFF);
        rchk(`STXEC_OFS_SERIAL_CONTROL_ZERO, 32'h000073E0, "serial_control_zero bits");
        chk({31'h0, cfg_o.pack_en}, 32'h1, "pack on");
        chk({30'h0, cfg_o.sclk_idle, cfg_o.capture_rise}, 32'h1, "fmt gate");
        apb(1'b1, `STXEC_OFS_SERIAL_CONTROL_ZERO, 32'h00000100);
        // Outputs follow the stored control one edge later
        @(posedge mclk);
        chk({30'h0, cfg_o.sclk_idle, cfg_o.capture_rise}, 32'h2, "pol1 ph0");
        apb(1'b1, `STXEC_OFS_SERIAL_CONTROL_ZERO, 32'h00000300);
        @(posedge mclk);
        chk({30'h0, cfg_o.sclk_idle, cfg_o.capture_rise}, 32'h3, "pol1 ph1");
        chk({31'h0, cfg_o.pack_en}, 32'h0, "pack off");
        ctrl_sel <= 1'b1;
        xfer_active <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `STXEC_OFS_SERIAL_CONTROL_ZERO, 32'(s) << 12);
            @(posedge mclk);
            chk({28'h0, cfg_o.cs_out_n}, {28'h0, ~(4'h1 << s)}, "cs line");
        end
        xfer_active <= 1'b0;
        ctrl_sel <= 1'b0;
        apb(1'b0, 16'h1004, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000, "unmapped");
        $display("t_ctl done");
    endtask

    task automatic t_link(input logic [31:0] ctl, input int n, input logic [31:0] e);
        apb(1'b1, `STXEC_OFS_SERIAL_CONTROL_ZERO, ctl);
        i_peer.open_frame(1);
        i_peer.clocks(n);
        repeat (8) @(posedge mclk);
        rchk(`STXEC_OFS_COUNT, 32'(n), "count in frame");
        i_peer.close_frame();
        repeat (8) @(posedge mclk);
        rchk(`STXEC_OFS_COUNT, e, "count after frame");
        $display("t_link done");
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_events();
        t_reeval();
        t_ctl();
        t_link(32'h00005000, 5, 32'h0);
        t_link(32'h00001000, 3, 32'h3);
        conclude();
    end

    initial begin
        #400000;
        miscompares++;
        conclude();
    end
endmodule
